// >>> duart_status_regs.sv
// Operation
// - Each stored character keeps its break, framing and parity flags.
// - A status read gives bits 7:5 from the head character in character mode, bits 4:0 live.
// - The reset-error-status command clears the per-character error bits.
// - In character mode a character's error bits go when it is read out.
// - In block mode errors stay until an error reset or a receiver reset.
// - In block mode each error bit ORs over all characters at the head.
`timescale 1ns/1ps
`default_nettype none

module duart_status_regs #(
    parameter int FIFO_DEPTH = duart_regs_pkg::RX_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic [1:0] rxPush,
    input wire logic [duart_regs_pkg::CHAR_W-1:0] rxCharA,
    input wire logic [duart_regs_pkg::CHAR_W-1:0] rxCharB,
    input wire logic [duart_regs_pkg::ERR_W-1:0] rxErrA,
    input wire logic [duart_regs_pkg::ERR_W-1:0] rxErrB,
    input wire logic [1:0] overrunFlag,
    input wire logic [1:0] transmitterEmptyFlag,
    input wire logic [1:0] transmitHoldingReadyFlag,
    input wire logic [1:0] breakChange,
    input wire logic counterReady,
    input wire logic [3:0] inputPins,
    output var logic [7:0] outputPins,
    output var logic [1:0] rxResetPulse,
    output var logic irq
);
    import duart_regs_pkg::*;

    localparam int WORD_W = CHAR_W + ERR_W;

    function automatic logic isMapped(input logic [5:0] idx);
        unique case (idx)
            IDX_STATUS_A, IDX_CMD_A, IDX_RXDATA_A, IDX_AUX, IDX_ISR,
            IDX_STATUS_B, IDX_CMD_B, IDX_RXDATA_B, IDX_OUTPUT_PIN_CONFIG, IDX_OP_SET,
            IDX_OP_CLR, IDX_ERRMODE, IDX_ISR_CLR, IDX_IMR: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    logic [5:0] idx;
    logic access;
    logic wrEn;
    logic rdEn;
    logic [7:0] rdMux;
    logic [7:0] opr_q;
    logic [7:0] output_pin_config_q;
    logic [7:0] acr_q;
    logic [7:0] imr_q;
    logic [7:0] isr_q;
    logic [1:0] errMode_q;
    logic [3:0] pinsMeta_q;
    logic [3:0] pinsSync_q;
    logic [3:0] pinsPrev_q;
    logic [1:0] primed_q;
    logic [3:0] delta_q;
    logic [3:0] newDelta;
    logic [1:0] txRdyPrev_q;
    logic [1:0] rxRdyPrev_q;
    logic [7:0] event_d;
    logic [1:0] cmdWr;
    logic [1:0] errReset;
    logic [1:0] rxReset;
    logic [1:0] rxPop;
    logic [1:0] fifoEmpty;
    logic [1:0] fifoFull;
    logic [7:0] statusWord [2];
    logic [CHAR_W-1:0] headChar [2];
    logic [CHAR_W-1:0] rxChar [2];
    logic [ERR_W-1:0] rxErr [2];
    logic [2:0] miscCmd;

    assign idx = paddr[7:2];
    assign access = psel && penable && pready;
    assign wrEn = access && pwrite && !pslverr;
    assign rdEn = access && !pwrite && !pslverr;
    assign miscCmd = pwdata[CMD_MISC_LSB +: 3];
    assign rxChar[0] = rxCharA;
    assign rxChar[1] = rxCharB;
    assign rxErr[0] = rxErrA;
    assign rxErr[1] = rxErrB;
    assign cmdWr[0] = wrEn && (idx == IDX_CMD_A);
    assign cmdWr[1] = wrEn && (idx == IDX_CMD_B);
    assign rxPop[0] = rdEn && (idx == IDX_RXDATA_A);
    assign rxPop[1] = rdEn && (idx == IDX_RXDATA_B);

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [WORD_W-1:0] headWord;
        logic headSeen_q;
        logic charCleared_q;
        logic [ERR_W-1:0] accum_q;
        logic [ERR_W-1:0] errBits;
        logic newHead;

        assign errReset[c] = cmdWr[c] && (miscCmd == CMD_RESET_ERR);
        assign rxReset[c] = cmdWr[c] && (miscCmd == CMD_RESET_RX);

        rx_status_fifo #(
            .DEPTH(FIFO_DEPTH),
            .WIDTH(WORD_W)
        ) u_fifo (
            .mclk(mclk),
            .reset(reset),
            .flush(rxReset[c]),
            .push(rxPush[c]),
            .pushWord({rxErr[c], rxChar[c]}),
            .pop(rxPop[c]),
            .headWord(headWord),
            .empty(fifoEmpty[c]),
            .full(fifoFull[c])
        );

        // A character counts once, on the first cycle it sits at the head.
        assign newHead = !fifoEmpty[c] && !headSeen_q;

        always_ff @(posedge mclk) begin
            if (reset || rxReset[c] || rxPop[c]) begin
                headSeen_q <= 1'b0;
            end else if (!fifoEmpty[c]) begin
                headSeen_q <= 1'b1;
            end
        end

        // A character reaching the head in an error or receiver reset cycle is still counted.
        always_ff @(posedge mclk) begin
            if (reset) begin
                accum_q <= '0;
            end else if (newHead) begin
                accum_q <= ((errReset[c] || rxReset[c]) ? '0 : accum_q)
                    | headWord[CHAR_W +: ERR_W];
            end else if (errReset[c] || rxReset[c]) begin
                accum_q <= '0;
            end
        end

        always_ff @(posedge mclk) begin
            if (reset || rxPop[c] || rxReset[c]) begin
                charCleared_q <= 1'b0;
            end else if (errReset[c] && !fifoEmpty[c]) begin
                charCleared_q <= 1'b1;
            end
        end

        assign errBits = errMode_q[c] ? accum_q
            : ((fifoEmpty[c] || charCleared_q) ? '0
            : headWord[CHAR_W +: ERR_W]);

        assign statusWord[c] = {errBits,
            overrunFlag[c], transmitterEmptyFlag[c],
            transmitHoldingReadyFlag[c], fifoFull[c],
            !fifoEmpty[c]};
        assign headChar[c] = headWord[CHAR_W-1:0];
    end

    always_comb begin
        unique case (idx)
            IDX_STATUS_A: rdMux = statusWord[0];
            IDX_STATUS_B: rdMux = statusWord[1];
            IDX_RXDATA_A: rdMux = headChar[0];
            IDX_RXDATA_B: rdMux = headChar[1];
            IDX_AUX: rdMux = {delta_q, pinsSync_q};
            IDX_ISR: rdMux = isr_q;
            IDX_OUTPUT_PIN_CONFIG: rdMux = opr_q;
            IDX_ERRMODE: rdMux = {6'h00, errMode_q};
            IDX_IMR: rdMux = imr_q;
            default: rdMux = 8'h00;
        endcase
    end

    // Every answer takes one wait cycle so that the bus outputs are flops.
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !isMapped(idx);
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdMux};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            output_pin_config_q <= OUTPUT_PIN_CONFIG_RESET;
            acr_q <= ACR_RESET;
            imr_q <= IMR_RESET;
            errMode_q <= ERRMODE_RESET;
        end else if (wrEn) begin
            unique case (idx)
                IDX_OUTPUT_PIN_CONFIG: output_pin_config_q <= pwdata[7:0];
                IDX_AUX: acr_q <= pwdata[7:0];
                IDX_IMR: imr_q <= pwdata[7:0];
                IDX_ERRMODE: errMode_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            opr_q <= OPR_RESET;
        end else if (wrEn && (idx == IDX_OP_SET)) begin
            opr_q <= opr_q | pwdata[7:0];
        end else if (wrEn && (idx == IDX_OP_CLR)) begin
            opr_q <= opr_q & ~pwdata[7:0];
        end
    end

    // A latch bit of one drives the pin low; selected status outputs are
    // active low in the same way.
    always_ff @(posedge mclk) begin
        if (reset) begin
            outputPins <= 8'hFF;
        end else begin
            outputPins[3:0] <= ~opr_q[3:0];
            outputPins[OUTPUT_PIN_CONFIG_RX_A] <= ~(output_pin_config_q[OUTPUT_PIN_CONFIG_RX_A] ? !fifoEmpty[0]
                : opr_q[OUTPUT_PIN_CONFIG_RX_A]);
            outputPins[OUTPUT_PIN_CONFIG_RX_B] <= ~(output_pin_config_q[OUTPUT_PIN_CONFIG_RX_B] ? !fifoEmpty[1]
                : opr_q[OUTPUT_PIN_CONFIG_RX_B]);
            outputPins[OUTPUT_PIN_CONFIG_TX_A] <= ~(output_pin_config_q[OUTPUT_PIN_CONFIG_TX_A]
                ? transmitHoldingReadyFlag[0] : opr_q[OUTPUT_PIN_CONFIG_TX_A]);
            outputPins[OUTPUT_PIN_CONFIG_TX_B] <= ~(output_pin_config_q[OUTPUT_PIN_CONFIG_TX_B]
                ? transmitHoldingReadyFlag[1] : opr_q[OUTPUT_PIN_CONFIG_TX_B]);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rxResetPulse <= 2'b00;
        end else begin
            rxResetPulse <= rxReset;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pinsMeta_q <= 4'h0;
            pinsSync_q <= 4'h0;
            pinsPrev_q <= 4'h0;
            primed_q <= 2'b00;
        end else begin
            pinsMeta_q <= inputPins;
            pinsSync_q <= pinsMeta_q;
            pinsPrev_q <= pinsSync_q;
            primed_q <= {primed_q[0], 1'b1};
        end
    end

    // Changes are ignored until the synchroniser holds real pin samples.
    assign newDelta = primed_q[1] ? (pinsSync_q ^ pinsPrev_q) : 4'h0;

    // Reading the input change register clears the deltas; a new change in
    // that cycle survives.
    always_ff @(posedge mclk) begin
        if (reset) begin
            delta_q <= 4'h0;
        end else if (rdEn && (idx == IDX_AUX)) begin
            delta_q <= newDelta;
        end else begin
            delta_q <= delta_q | newDelta;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            txRdyPrev_q <= 2'b00;
            rxRdyPrev_q <= 2'b00;
        end else begin
            txRdyPrev_q <= transmitHoldingReadyFlag;
            rxRdyPrev_q <= ~fifoEmpty;
        end
    end

    always_comb begin
        event_d = 8'h00;
        for (int c = 0; c < 2; c++) begin
            event_d[ISR_TX_READY + c * ISR_CH_STRIDE] =
                transmitHoldingReadyFlag[c] && !txRdyPrev_q[c];
            event_d[ISR_RX_READY + c * ISR_CH_STRIDE] =
                !fifoEmpty[c] && !rxRdyPrev_q[c];
            event_d[ISR_BREAK + c * ISR_CH_STRIDE] = breakChange[c];
        end
        event_d[ISR_COUNTER] = counterReady;
        event_d[ISR_INPUT_CHANGE] = |(newDelta & acr_q[3:0]);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            isr_q <= ISR_RESET;
        end else if (wrEn && (idx == IDX_ISR_CLR)) begin
            isr_q <= (isr_q & ~pwdata[7:0]) | event_d;
        end else begin
            isr_q <= isr_q | event_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(isr_q & imr_q);
        end
    end
endmodule

`default_nettype wire

// >>> duart_regs_pkg.sv
`default_nettype none
package duart_regs_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_STATUS_A = 6'h01;
    localparam logic [5:0] IDX_CMD_A = 6'h02;
    localparam logic [5:0] IDX_RXDATA_A = 6'h03;
    localparam logic [5:0] IDX_AUX = 6'h04;
    localparam logic [5:0] IDX_ISR = 6'h05;
    localparam logic [5:0] IDX_STATUS_B = 6'h09;
    localparam logic [5:0] IDX_CMD_B = 6'h0A;
    localparam logic [5:0] IDX_RXDATA_B = 6'h0B;
    localparam logic [5:0] IDX_OUTPUT_PIN_CONFIG = 6'h0D;
    localparam logic [5:0] IDX_OP_SET = 6'h0E;
    localparam logic [5:0] IDX_OP_CLR = 6'h0F;
    localparam logic [5:0] IDX_ERRMODE = 6'h10;
    localparam logic [5:0] IDX_ISR_CLR = 6'h11;
    localparam logic [5:0] IDX_IMR = 6'h12;

    // Channel command field.
    localparam int CMD_MISC_LSB = 4;
    localparam logic [2:0] CMD_RESET_RX = 3'h2;
    localparam logic [2:0] CMD_RESET_ERR = 3'h4;

    // Channel status layout.
    localparam int SR_ERR_LSB = 5;
    localparam int SR_OVERRUN = 4;
    localparam int SR_TX_EMPTY = 3;
    localparam int SR_TX_READY = 2;
    localparam int SR_FIFO_FULL = 1;
    localparam int SR_RX_READY = 0;

    // Interrupt status layout; channel B sits four bits above channel A.
    localparam int ISR_TX_READY = 0;
    localparam int ISR_RX_READY = 1;
    localparam int ISR_BREAK = 2;
    localparam int ISR_COUNTER = 3;
    localparam int ISR_CH_STRIDE = 4;
    localparam int ISR_INPUT_CHANGE = 7;

    // Output configuration: bits 4..7 pick a live status instead of the latch.
    localparam int OUTPUT_PIN_CONFIG_RX_A = 4;
    localparam int OUTPUT_PIN_CONFIG_RX_B = 5;
    localparam int OUTPUT_PIN_CONFIG_TX_A = 6;
    localparam int OUTPUT_PIN_CONFIG_TX_B = 7;

    localparam logic [7:0] OPR_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_PIN_CONFIG_RESET = 8'h00;
    localparam logic [7:0] ACR_RESET = 8'h00;
    localparam logic [7:0] IMR_RESET = 8'h00;
    localparam logic [7:0] ISR_RESET = 8'h00;
    localparam logic [1:0] ERRMODE_RESET = 2'h0;

    localparam int RX_FIFO_DEPTH = 8;
    localparam int CHAR_W = 8;
    localparam int ERR_W = 3;

endpackage

`default_nettype wire

// >>> rx_status_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module rx_status_fifo #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 11
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushWord,
    input wire logic pop,
    output logic [WIDTH-1:0] headWord,
    output logic empty,
    output logic full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] rdPtr_q;
    logic [PW-1:0] wrPtr_q;
    logic [CW-1:0] count_q;
    logic doPush;
    logic doPop;

    assign empty = (count_q == '0);
    assign full = (count_q == FULL_COUNT);
    assign doPop = pop && !empty;
    // A character arriving into a full FIFO is lost; overrun is flagged
    // by the receiver itself.
    assign doPush = push && !full;
    assign headWord = mem[rdPtr_q];

    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_q] <= pushWord;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || flush) begin
            rdPtr_q <= '0;
            wrPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            end
            if (doPush && !doPop) begin
                count_q <= count_q + 1'b1;
            end else if (doPop && !doPush) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> duart_status_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module duart_status_regs_assertions #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] rxPush,
    input wire logic [1:0] overrunFlag,
    input wire logic [1:0] transmitterEmptyFlag,
    input wire logic [1:0] transmitHoldingReadyFlag,
    input wire logic [7:0] outputPins,
    input wire logic [1:0] rxResetPulse,
    input wire logic irq
);
    import duart_regs_pkg::*;
    logic [5:0] idx;
    logic rdDone, wrDone, rxFlushA;
    logic [7:0] levelA_q;
    assign idx = paddr[7:2];
    assign rdDone = psel && penable && pready && !pwrite;
    assign wrDone = psel && penable && pready && pwrite;
    assign rxFlushA = wrDone && idx == IDX_CMD_A
        && pwdata[CMD_MISC_LSB +: 3] == CMD_RESET_RX;
    // Shadow fill level of queue A; pushes and pops never share a cycle.
    always_ff @(posedge mclk) begin
        if (reset || rxFlushA) begin
            levelA_q <= 8'h00;
        end else if (rxPush[0] && levelA_q < FIFO_DEPTH) begin
            levelA_q <= levelA_q + 8'h01;
        end else if (rdDone && idx == IDX_RXDATA_A && levelA_q != 8'h00) begin
            levelA_q <= levelA_q - 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    status_word_a: assert property (
        rdDone && idx == IDX_STATUS_A |-> prdata[31:8] == 24'h000000 && !pslverr)
        else $error("status read word malformed");
    live_flags_a: assert property (
        rdDone && idx == IDX_STATUS_A && $stable(overrunFlag)
        && $stable(transmitterEmptyFlag) && $stable(transmitHoldingReadyFlag)
        |-> prdata[4:2] == {overrunFlag[0], transmitterEmptyFlag[0],
        transmitHoldingReadyFlag[0]})
        else $error("channel A live bits wrong");
    live_flags_b_a: assert property (
        rdDone && idx == IDX_STATUS_B && $stable(overrunFlag)
        && $stable(transmitterEmptyFlag) && $stable(transmitHoldingReadyFlag)
        |-> prdata[4:2] == {overrunFlag[1], transmitterEmptyFlag[1],
        transmitHoldingReadyFlag[1]})
        else $error("channel B live bits wrong");
    fifo_level_a: assert property (
        rdDone && idx == IDX_STATUS_A
        |-> prdata[1:0] == {levelA_q == FIFO_DEPTH, levelA_q != 8'h00})
        else $error("channel A fill bits wrong");
    rx_flush_a: assert property (
        rxFlushA |-> ##[1:2] rxResetPulse[0])
        else $error("receiver reset pulse missing");
    one_wait_a: assert property (
        psel && $rose(penable) |-> !pready ##1 pready)
        else $error("transfer did not take one wait state");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error response without ready");
    reset_idle_a: assert property (disable iff (1'b0)
        reset |=> !pready && !irq && prdata == 32'h0 && outputPins == 8'hFF)
        else $error("outputs not idle after reset");
endmodule
bind duart_status_regs duart_status_regs_assertions #(
    .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPush(rxPush),
    .overrunFlag(overrunFlag), .transmitterEmptyFlag(transmitterEmptyFlag),
    .transmitHoldingReadyFlag(transmitHoldingReadyFlag),
    .outputPins(outputPins), .rxResetPulse(rxResetPulse), .irq(irq));
`default_nettype wire

// >>> rx_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module rx_side_model (
    input wire logic mclk,
    output logic [1:0] rxPush,
    output logic [7:0] rxCharA,
    output logic [7:0] rxCharB,
    output logic [2:0] rxErrA,
    output logic [2:0] rxErrB,
    output logic [1:0] overrunFlag,
    output logic [1:0] transmitterEmptyFlag,
    output logic [1:0] transmitHoldingReadyFlag,
    output logic [1:0] breakChange,
    output logic counterReady,
    output logic [3:0] inputPins
);
    initial begin
        {rxPush, rxCharA, rxCharB, rxErrA, rxErrB} = '0;
        {overrunFlag, transmitterEmptyFlag, transmitHoldingReadyFlag} = '0;
        {breakChange, counterReady, inputPins} = '0;
    end
    task automatic push(input int ch, input logic [7:0] c,
                        input logic [2:0] e);
        @(posedge mclk);
        rxPush[ch] <= 1'b1;
        if (ch == 0) begin
            rxCharA <= c;
            rxErrA <= e;
        end else begin
            rxCharB <= c;
            rxErrB <= e;
        end
        @(posedge mclk);
        rxPush <= 2'b00;
        // Data is meaningless outside the push, so it is scrambled.
        {rxCharA, rxCharB} <= ~{rxCharA, rxCharB};
        {rxErrA, rxErrB} <= ~{rxErrA, rxErrB};
    endtask
    task automatic live(input logic [5:0] v);
        @(posedge mclk);
        overrunFlag <= v[1:0];
        transmitterEmptyFlag <= v[3:2];
        transmitHoldingReadyFlag <= v[5:4];
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge mclk);
        counterReady <= m[0];
        breakChange <= m[2:1];
        @(posedge mclk);
        counterReady <= 1'b0;
        breakChange <= 2'b00;
    endtask
    task automatic pins(input logic [3:0] v);
        @(posedge mclk);
        inputPins <= v;
    endtask
endmodule
`default_nettype wire

// >>> test_duart_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_duart_status_regs;
    import duart_regs_pkg::*;
    localparam int DEPTH = 4;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, counterReady, irq;
    wire logic [1:0] rxPush, overrunFlag, transmitterEmptyFlag;
    wire logic [1:0] transmitHoldingReadyFlag, breakChange, rxResetPulse;
    wire logic [7:0] rxCharA, rxCharB, outputPins;
    wire logic [2:0] rxErrA, rxErrB;
    wire logic [3:0] inputPins;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rdv;
    logic errv;
    initial begin
        forever #10 mclk = ~mclk;
    end
    duart_status_regs #(.FIFO_DEPTH(DEPTH)) u_duart_status_regs (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxPush(rxPush),
        .rxCharA(rxCharA), .rxCharB(rxCharB), .rxErrA(rxErrA),
        .rxErrB(rxErrB), .overrunFlag(overrunFlag),
        .transmitterEmptyFlag(transmitterEmptyFlag),
        .transmitHoldingReadyFlag(transmitHoldingReadyFlag),
        .breakChange(breakChange), .counterReady(counterReady),
        .inputPins(inputPins), .outputPins(outputPins),
        .rxResetPulse(rxResetPulse), .irq(irq));
    rx_side_model u_rx_side_model (.mclk(mclk), .rxPush(rxPush),
        .rxCharA(rxCharA), .rxCharB(rxCharB), .rxErrA(rxErrA),
        .rxErrB(rxErrB), .overrunFlag(overrunFlag),
        .transmitterEmptyFlag(transmitterEmptyFlag),
        .transmitHoldingReadyFlag(transmitHoldingReadyFlag),
        .breakChange(breakChange), .counterReady(counterReady),
        .inputPins(inputPins));
    function automatic logic [31:0] stat(input logic [2:0] e,
        input logic [2:0] l, input logic [1:0] f);
        return {24'h0, e, l, f};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("Error pready expected 1 seen 0");
            give_verdict();
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    initial begin
        logic [7:0] c, v, w;
        logic [2:0] e, acc, lvA, lvB;
        logic [5:0] lv;
        logic [10:0] q[$];
        logic [5:0] rstIdx[8];
        logic [7:0] evBit[3];
        void'($urandom(32'h3130DA54));
        rstIdx = '{IDX_STATUS_A, IDX_STATUS_B, IDX_AUX, IDX_ISR, IDX_OUTPUT_PIN_CONFIG,
                   IDX_ERRMODE, IDX_IMR, IDX_CMD_A};
        evBit = '{8'h08, 8'h04, 8'h40};
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        foreach (rstIdx[i]) begin
            apb(1'b0, rstIdx[i], 8'h00);
            chk("reset value", 32'h0, rdv);
        end
        apb(1'b0, 6'h3F, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, errv});
        v = 8'($urandom);
        w = 8'($urandom);
        apb(1'b1, IDX_OP_SET, v);
        apb(1'b1, IDX_OP_CLR, w);
        apb(1'b0, IDX_OUTPUT_PIN_CONFIG, 8'h00);
        chk("latch", {24'h0, v & ~w}, rdv);
        settle(2);
        chk("pins", {24'h0, ~(v & ~w)}, {24'h0, outputPins});
        lv = 6'($urandom);
        lvA = {lv[0], lv[2], lv[4]};
        lvB = {lv[1], lv[3], lv[5]};
        u_rx_side_model.live(lv);
        apb(1'b1, IDX_OUTPUT_PIN_CONFIG, 8'hF0);
        settle(2);
        chk("pins", {24'h0, ~lv[5], ~lv[4], 2'b11, ~(v[3:0] & ~w[3:0])},
            {24'h0, outputPins});
        for (int i = 0; i <= DEPTH; i++) begin
            c = 8'($urandom);
            e = 3'($urandom);
            u_rx_side_model.push(0, c, e);
            if (i < DEPTH) q.push_back({e, c});
        end
        for (int i = 0; i < DEPTH; i++) begin
            apb(1'b0, IDX_STATUS_A, 8'h00);
            e = q[i][10:8];
            chk("status A", stat(e, lvA, {i == 0, 1'b1}), rdv);
            apb(1'b0, IDX_RXDATA_A, 8'h00);
            chk("char A", {24'h0, q[i][7:0]}, rdv);
        end
        apb(1'b0, IDX_STATUS_A, 8'h00);
        chk("status A", stat(3'b000, lvA, 2'b00), rdv);
        apb(1'b0, IDX_STATUS_B, 8'h00);
        chk("status B", stat(3'b000, lvB, 2'b00), rdv);
        u_rx_side_model.push(0, 8'h5A, 3'b111);
        apb(1'b1, IDX_CMD_A, {1'b0, CMD_RESET_ERR, 4'h0});
        apb(1'b0, IDX_STATUS_A, 8'h00);
        chk("status A", stat(3'b000, lvA, 2'b01), rdv);
        apb(1'b1, IDX_CMD_A, {1'b0, CMD_RESET_RX, 4'h0});
        apb(1'b0, IDX_STATUS_A, 8'h00);
        chk("status A", stat(3'b000, lvA, 2'b00), rdv);
        apb(1'b1, IDX_ERRMODE, 8'h02);
        acc = 3'b000;
        for (int i = 0; i < 3; i++) begin
            c = 8'($urandom);
            e = 3'($urandom);
            acc |= e;
            u_rx_side_model.push(1, c, e);
        end
        repeat (3) apb(1'b0, IDX_RXDATA_B, 8'h00);
        apb(1'b0, IDX_STATUS_B, 8'h00);
        chk("status B", stat(acc, lvB, 2'b00), rdv);
        apb(1'b1, IDX_CMD_B, {1'b0, CMD_RESET_ERR, 4'h0});
        apb(1'b0, IDX_STATUS_B, 8'h00);
        chk("status B", stat(3'b000, lvB, 2'b00), rdv);
        u_rx_side_model.push(1, 8'hA5, 3'b100);
        apb(1'b0, IDX_RXDATA_B, 8'h00);
        apb(1'b0, IDX_STATUS_B, 8'h00);
        chk("status B", stat(3'b100, lvB, 2'b00), rdv);
        apb(1'b1, IDX_CMD_B, {1'b0, CMD_RESET_RX, 4'h0});
        apb(1'b0, IDX_STATUS_B, 8'h00);
        chk("status B", stat(3'b000, lvB, 2'b00), rdv);
        apb(1'b1, IDX_ISR_CLR, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, IDX_IMR, 8'h00);
            u_rx_side_model.pulse(3'b001 << k);
            apb(1'b0, IDX_ISR, 8'h00);
            chk("isr", {24'h0, evBit[k]}, rdv);
            settle(2);
            chk("irq masked", 32'h0, {31'h0, irq});
            apb(1'b1, IDX_IMR, evBit[k]);
            settle(2);
            chk("irq", 32'h1, {31'h0, irq});
            apb(1'b1, IDX_ISR_CLR, evBit[k]);
            settle(2);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        apb(1'b1, IDX_AUX, 8'h0F);
        v = 8'($urandom);
        v[0] = 1'b1;
        u_rx_side_model.pins(v[3:0]);
        settle(4);
        apb(1'b0, IDX_AUX, 8'h00);
        chk("input change", {24'h0, v[3:0], v[3:0]}, rdv);
        apb(1'b0, IDX_ISR, 8'h00);
        chk("isr", 32'h80, rdv);
        give_verdict();
    end
endmodule
`default_nettype wire
